// ### design/tlp_regs.svh
`ifndef TLP_REGS_SVH
`define TLP_REGS_SVH

// register byte offsets
`define TLP_CTRL_OFS        8'h00
`define TLP_STATUS_OFS      8'h04
`define TLP_INT_STATUS_OFS  8'h08
`define TLP_INT_MASK_OFS    8'h0c

// control register fields
`define TLP_CTRL_UNIPOLAR   0
`define TLP_CTRL_QRSS       1
`define TLP_CTRL_EDGE_SEL   2
`define TLP_CTRL_LOOP_LO    3
`define TLP_CTRL_LOOP_HI    4
`define TLP_CTRL_W          5
`define TLP_CTRL_RESET      5'h00

// status register fields
`define TLP_STAT_TXCLK_OK   0
`define TLP_STAT_LOS        1
`define TLP_STAT_RXC_MCLK   2

// interrupt status / mask fields
`define TLP_INT_LER         0
`define TLP_INT_VIO         1
`define TLP_INT_RXVIO       2
`define TLP_INT_LOS         3
`define TLP_INT_TXCLK       4
`define TLP_INT_W           5
`define TLP_INT_MASK_RESET  5'h00

// bus responses
`define TLP_RESP_OKAY       2'b00
`define TLP_RESP_SLVERR     2'b10

// synchroniser slots
`define TLP_NSYNC           11
`define TLP_SI_TRANSMIT_CLOCK         0
`define TLP_SI_MCLK         1
`define TLP_SI_LCLK         2
`define TLP_SI_TX_POSITIVE_RAIL         3
`define TLP_SI_TX_NEGATIVE_RAIL         4
`define TLP_SI_LER          5
`define TLP_SI_VIO          6
`define TLP_SI_LPOS         7
`define TLP_SI_LNEG         8
`define TLP_SI_LOS          9
`define TLP_SI_FLOAT        10

// test pattern generator, x^20 + x^17 + 1
`define TLP_PRBS_SEED       20'hfffff
`define TLP_PRBS_TAP_A      19
`define TLP_PRBS_TAP_B      16

// timing
`define TLP_CLK_NS          10
`define TLP_TXCLK_LOSS_NS   2000
`define TLP_TXCLK_LOSS_CYC  ((`TLP_TXCLK_LOSS_NS + `TLP_CLK_NS - 1) / `TLP_CLK_NS)
`define TLP_CNT_W           16

`endif

// ### design/tlp_pkg.sv
`include "tlp_regs.svh"

package tlp_pkg;

   typedef enum logic [1:0] {
      tlp_lb_none,
      tlp_lb_local,
      tlp_lb_remote,
      tlp_lb_rsvd
   } tlp_loop_t;

   typedef struct packed {
      logic [`TLP_NSYNC-1:0]  s1;
      logic [`TLP_NSYNC-1:0]  s2;
      logic [`TLP_NSYNC-1:0]  s3;
      logic [`TLP_CNT_W-1:0]  idle_cnt;
      logic                   tx_clk_ok;
      logic                   ler_prev;
      logic                   vio_prev;
      logic [19:0]            prbs;
      logic                   last_pol;
      logic                   line_p;
      logic                   line_n;
      logic                   rx_sym_p;
      logic                   rx_sym_n;
      logic                   rx_mark_seen;
      logic                   rx_last_pol;
      logic                   rx_vio;
      logic                   los_prev;
      logic                   rxc_sel;
      logic                   rxc_out;
      logic                   rx_pos_out;
      logic                   rx_neg_out;
      logic                   rx_vio_out;
      logic                   pins_oe;
      logic [`TLP_CTRL_W-1:0] ctrl;
      logic [`TLP_INT_W-1:0]  ists;
      logic [`TLP_INT_W-1:0]  mask;
      logic                   irq;
      logic                   aw_full;
      logic                   w_full;
      logic [7:0]             awaddr;
      logic [`TLP_CTRL_W-1:0] wdata;
      logic                   wstrb0;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   rvalid;
      logic [1:0]             rresp;
      logic [`TLP_CTRL_W-1:0] rdata;
   } tlp_state_t;

endpackage : tlp_pkg

// ### design/tlp_line_port.sv
// What this block does
// - bipolar rails sampled on transmit or master fall
// - unipolar data taken from positive rail
// - each error-input rise flips one pattern bit unless a violation replaces that bit
// - pattern error follows active loopback path
// - error input sampled on transmit/master falling edge
// - violation input sampled on transmit/master falling edge
// - one violation per rise of violation input in unipolar or test mode
// - test mode puts violations into pattern
// - floating strobe pin clears the output enable pins_oe
// - bipolar receive rails mirror line pulse polarity
// - edge select picks stable recovered clock edge
// - unipolar violation flag valid at rising edge
// - unipolar receive data on single rail
// - recovered clock output aligned with receive data
// - glitch-free switch to master clock on loss
`include "tlp_regs.svh"

module tlp_line_port #(
   parameter int TXCLK_LOSS_CYC = `TLP_TXCLK_LOSS_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        transmit_clock,
   input  wire logic        master_clock,
   input  wire logic        tx_positive_rail,
   input  wire logic        tx_negative_rail,
   input  wire logic        insert_logic_error_in,
   input  wire logic        insert_violation_in,
   input  wire logic        line_rx_clock,
   input  wire logic        line_rx_pos,
   input  wire logic        line_rx_neg,
   input  wire logic        loss_of_signal,
   input  wire logic        address_latch_strobe_float,
   output logic             line_tx_pos,
   output logic             line_tx_neg,
   output logic             rx_positive_rail,
   output logic             rx_negative_rail,
   output logic             rx_violation_flag,
   output logic             recovered_clock,
   output logic             pins_oe,
   output logic             irq,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   import tlp_pkg::*;

   if (TXCLK_LOSS_CYC < 2 || TXCLK_LOSS_CYC >= (1 << `TLP_CNT_W)) begin : g_chk
      $error("TXCLK_LOSS_CYC out of range");
   end

   tlp_state_t r;
   tlp_state_t n;

   logic [`TLP_NSYNC-1:0] rise;
   logic [`TLP_NSYNC-1:0] fall;
   logic                  uni;
   logic                  qrss;
   logic                  edge_sel;
   tlp_loop_t             loop;
   logic                  tx_edge;
   logic                  ler_ev;
   logic                  vio_ev;
   logic                  tbit;
   logic                  tsp;
   logic                  tsn;
   logic                  rx_from_tx;
   logic                  rx_take;
   logic                  rp_in;
   logic                  rn_in;
   logic                  viol;
   logic                  want_mclk;
   logic                  src;
   logic                  rxc_rise;
   logic                  rxc_fall;
   logic [`TLP_INT_W-1:0] set;
   logic [`TLP_INT_W-1:0] clr;

   always_comb begin
      n = r;
      set = '0;
      clr = '0;
      uni = r.ctrl[`TLP_CTRL_UNIPOLAR];
      qrss = r.ctrl[`TLP_CTRL_QRSS];
      edge_sel = r.ctrl[`TLP_CTRL_EDGE_SEL];
      loop = tlp_loop_t'(r.ctrl[`TLP_CTRL_LOOP_HI:`TLP_CTRL_LOOP_LO]);

      // pin synchronisers, edges seen between stage two and three
      n.s1 = {address_latch_strobe_float, loss_of_signal, line_rx_neg, line_rx_pos, insert_violation_in,
              insert_logic_error_in, tx_negative_rail, tx_positive_rail, line_rx_clock, master_clock,
              transmit_clock};
      n.s2 = r.s1;
      n.s3 = r.s2;
      rise = r.s2 & ~r.s3;
      fall = ~r.s2 & r.s3;

      // transmit clock activity watchdog
      if (rise[`TLP_SI_TRANSMIT_CLOCK] | fall[`TLP_SI_TRANSMIT_CLOCK]) begin
         n.idle_cnt = '0;
         n.tx_clk_ok = 1'b1;
      end else if (r.idle_cnt == `TLP_CNT_W'(TXCLK_LOSS_CYC - 1)) begin
         n.tx_clk_ok = 1'b0;
      end else begin
         n.idle_cnt = r.idle_cnt + `TLP_CNT_W'(1);
      end
      if (n.tx_clk_ok != r.tx_clk_ok) begin
         set[`TLP_INT_TXCLK] = 1'b1;
      end

      // one sampling edge for every transmit-side input
      tx_edge = r.tx_clk_ok ? fall[`TLP_SI_TRANSMIT_CLOCK] : fall[`TLP_SI_MCLK];

      ler_ev = 1'b0;
      vio_ev = 1'b0;
      tbit = 1'b0;
      tsp = r.line_p;
      tsn = r.line_n;
      if (tx_edge) begin
         ler_ev = qrss & r.s2[`TLP_SI_LER] & ~r.ler_prev;
         vio_ev = (uni | qrss) & r.s2[`TLP_SI_VIO] & ~r.vio_prev;
         n.ler_prev = r.s2[`TLP_SI_LER];
         n.vio_prev = r.s2[`TLP_SI_VIO];
         if (qrss) begin
            tbit = r.prbs[`TLP_PRBS_TAP_A] ^ ler_ev;
            n.prbs = {r.prbs[18:0], r.prbs[`TLP_PRBS_TAP_A] ^ r.prbs[`TLP_PRBS_TAP_B]};
         end else begin
            tbit = r.s2[`TLP_SI_TX_POSITIVE_RAIL];
         end
         if (!uni && !qrss) begin
            tsp = r.s2[`TLP_SI_TX_POSITIVE_RAIL];
            tsn = r.s2[`TLP_SI_TX_NEGATIVE_RAIL];
         end else if (vio_ev) begin
            // repeat last polarity, into the pattern when in test mode
            tsp = r.last_pol;
            tsn = ~r.last_pol;
         end else if (tbit) begin
            tsp = ~r.last_pol;
            tsn = r.last_pol;
            n.last_pol = ~r.last_pol;
         end else begin
            tsp = 1'b0;
            tsn = 1'b0;
         end
         if (loop == tlp_lb_remote) begin
            n.line_p = r.rx_sym_p;
            n.line_n = r.rx_sym_n;
         end else begin
            n.line_p = tsp;
            n.line_n = tsn;
         end
      end
      if (ler_ev) begin
         set[`TLP_INT_LER] = 1'b1;
      end
      if (vio_ev) begin
         set[`TLP_INT_VIO] = 1'b1;
      end

      // receive symbol capture; pattern goes where the loopback routes it
      rx_from_tx = (loop == tlp_lb_local) | ((loop == tlp_lb_remote) & qrss);
      rx_take = rx_from_tx ? tx_edge : (rise[`TLP_SI_LCLK] & ~r.s2[`TLP_SI_LOS]);
      rp_in = rx_from_tx ? tsp : r.s2[`TLP_SI_LPOS];
      rn_in = rx_from_tx ? tsn : r.s2[`TLP_SI_LNEG];
      viol = 1'b0;
      if (rx_take) begin
         n.rx_sym_p = rp_in;
         n.rx_sym_n = rn_in;
         if (rp_in ^ rn_in) begin
            viol = r.rx_mark_seen & (rp_in == r.rx_last_pol);
            n.rx_last_pol = rp_in;
            n.rx_mark_seen = 1'b1;
         end
         n.rx_vio = viol;
      end else if (r.s2[`TLP_SI_LOS] && !rx_from_tx) begin
         n.rx_sym_p = 1'b0;
         n.rx_sym_n = 1'b0;
         n.rx_vio = 1'b0;
      end
      if (viol) begin
         set[`TLP_INT_RXVIO] = 1'b1;
      end
      n.los_prev = r.s2[`TLP_SI_LOS];
      if (r.s2[`TLP_SI_LOS] != r.los_prev) begin
         set[`TLP_INT_LOS] = 1'b1;
      end

      // recovered clock; source swapped only while output is low, at a fall of the new source
      want_mclk = r.s2[`TLP_SI_LOS] | rx_from_tx;
      src = r.rxc_sel ? r.s2[`TLP_SI_MCLK] : r.s2[`TLP_SI_LCLK];
      if (r.rxc_sel != want_mclk && !r.rxc_out) begin
         // held low until the hand-over, so no runt low phase follows it
         src = 1'b0;
         if (want_mclk ? fall[`TLP_SI_MCLK] : fall[`TLP_SI_LCLK]) begin
            n.rxc_sel = want_mclk;
         end
      end
      n.rxc_out = src;
      rxc_rise = src & ~r.rxc_out;
      rxc_fall = ~src & r.rxc_out;

      // data change on the edge opposite to the one it is valid on
      if (edge_sel ? rxc_rise : rxc_fall) begin
         if (uni) begin
            n.rx_pos_out = r.rx_sym_p | r.rx_sym_n;
            n.rx_neg_out = 1'b0;
         end else begin
            n.rx_pos_out = r.rx_sym_p;
            n.rx_neg_out = r.rx_sym_n;
         end
      end
      if (rxc_fall) begin
         n.rx_vio_out = uni & r.rx_vio;
      end

      n.pins_oe = ~r.s2[`TLP_SI_FLOAT];

      // axi4-lite read
      if (r.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !r.rvalid) begin
         n.rvalid = 1'b1;
         n.rresp = `TLP_RESP_OKAY;
         n.rdata = '0;
         case (s_axi_araddr)
            `TLP_CTRL_OFS: n.rdata = r.ctrl;
            `TLP_STATUS_OFS: begin
               n.rdata[`TLP_STAT_TXCLK_OK] = r.tx_clk_ok;
               n.rdata[`TLP_STAT_LOS] = r.s2[`TLP_SI_LOS];
               n.rdata[`TLP_STAT_RXC_MCLK] = r.rxc_sel;
            end
            `TLP_INT_STATUS_OFS: begin
               n.rdata = r.ists;
               clr = r.ists;
            end
            `TLP_INT_MASK_OFS: n.rdata = r.mask;
            default: n.rresp = `TLP_RESP_SLVERR;
         endcase
      end

      // axi4-lite write, address and data in either order
      if (r.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (s_axi_awvalid && !r.aw_full && !r.bvalid) begin
         n.aw_full = 1'b1;
         n.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r.w_full && !r.bvalid) begin
         n.w_full = 1'b1;
         n.wdata = s_axi_wdata[`TLP_CTRL_W-1:0];
         n.wstrb0 = s_axi_wstrb[0];
      end
      if (r.aw_full && r.w_full && !r.bvalid) begin
         n.aw_full = 1'b0;
         n.w_full = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `TLP_RESP_OKAY;
         case (r.awaddr)
            `TLP_CTRL_OFS: begin
               if (r.wstrb0) begin
                  n.ctrl = r.wdata;
               end
            end
            `TLP_INT_MASK_OFS: begin
               if (r.wstrb0) begin
                  n.mask = r.wdata;
               end
            end
            `TLP_STATUS_OFS, `TLP_INT_STATUS_OFS: n.bresp = `TLP_RESP_OKAY;
            default: n.bresp = `TLP_RESP_SLVERR;
         endcase
      end

      // new events win over a clearing read
      n.ists = (r.ists & ~clr) | set;
      n.irq = |(n.ists & n.mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.prbs <= `TLP_PRBS_SEED;
         r.ctrl <= `TLP_CTRL_RESET;
         r.mask <= `TLP_INT_MASK_RESET;
      end else begin
         r <= n;
      end
   end

   assign line_tx_pos       = r.line_p;
   assign line_tx_neg       = r.line_n;
   assign rx_positive_rail  = r.rx_pos_out;
   assign rx_negative_rail  = r.rx_neg_out;
   assign rx_violation_flag = r.rx_vio_out;
   assign recovered_clock   = r.rxc_out;
   assign pins_oe           = r.pins_oe;
   assign irq               = r.irq;
   assign s_axi_awready     = ~r.aw_full & ~r.bvalid;
   assign s_axi_wready      = ~r.w_full & ~r.bvalid;
   assign s_axi_bvalid      = r.bvalid;
   assign s_axi_bresp       = r.bresp;
   assign s_axi_arready     = ~r.rvalid;
   assign s_axi_rvalid      = r.rvalid;
   assign s_axi_rresp       = r.rresp;
   assign s_axi_rdata       = {{(32 - `TLP_CTRL_W){1'b0}}, r.rdata};

endmodule : tlp_line_port

// ### verification/tlp_line_port_properties.sv
module tlp_line_port_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic transmit_clock,
   input wire logic master_clock,
   input wire logic address_latch_strobe_float,
   input wire logic line_tx_pos,
   input wire logic rx_positive_rail,
   input wire logic recovered_clock,
   input wire logic pins_oe,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [2:0] tck_q;
   logic [2:0] mck_q;
   logic [7:0] since_fall;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // cycles since a sampling fall reached the synchronisers
   always_ff @(posedge aclk) begin
      tck_q <= {tck_q[1:0], transmit_clock};
      mck_q <= {mck_q[1:0], master_clock};
      if (!aresetn || (tck_q[2] && !tck_q[1]) || (mck_q[2] && !mck_q[1]))
         since_fall <= 8'h0;
      else if (since_fall != 8'hff)
         since_fall <= since_fall + 8'h1;
   end

   a_oe_float: assert property (address_latch_strobe_float |-> ##[1:4] !pins_oe)
      else $error("outputs enabled while strobe floats");
   a_wr_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   a_rd_block: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer not withdrawn after handshake");
   a_tx_align: assert property (
      $changed(line_tx_pos) && pins_oe && $past(pins_oe) |-> since_fall < 8'h4)
      else $error("transmit symbol moved off a sampling fall");
   a_rx_align: assert property (
      $changed(rx_positive_rail) && pins_oe && $past(pins_oe)
      |-> $changed(recovered_clock) || ($past(recovered_clock) != $past(recovered_clock, 2)))
      else $error("receive data moved off a recovered clock edge");
   a_rc_high: assert property (
      $rose(recovered_clock) && $past(pins_oe) |=> (recovered_clock || !pins_oe)[*4])
      else $error("short high pulse on recovered clock");
   a_rc_low: assert property (
      $fell(recovered_clock) && pins_oe |=> (!recovered_clock || !pins_oe)[*4])
      else $error("short low pulse on recovered clock");

   c_float: cover property (!pins_oe);
   c_read: cover property (s_axi_arvalid && s_axi_arready);
   c_tx: cover property ($rose(line_tx_pos));
endmodule : tlp_line_port_properties

bind tlp_line_port tlp_line_port_properties i_tlp_line_port_properties (.aclk, .aresetn, .transmit_clock,
   .master_clock, .address_latch_strobe_float, .line_tx_pos, .rx_positive_rail, .recovered_clock, .pins_oe,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

// ### verification/tlp_far_end.sv
module tlp_far_end (
   input  wire logic tx_run,
   input  wire logic rx_run,
   input  wire logic tx_p_in,
   input  wire logic tx_n_in,
   input  wire logic rx_p_in,
   input  wire logic rx_n_in,
   output logic      transmit_clock,
   output logic      master_clock,
   output logic      tx_positive_rail,
   output logic      tx_negative_rail,
   output logic      line_rx_clock,
   output logic      line_rx_pos,
   output logic      line_rx_neg
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {transmit_clock, master_clock, line_rx_clock} = 3'h0;
      {tx_positive_rail, tx_negative_rail, line_rx_pos, line_rx_neg} = 4'h0;
      #3;
      fork
         forever #244.1 master_clock = ~master_clock;
         forever begin
            #62.5;
            // clocks stop low outside frames
            if (tx_run || transmit_clock) transmit_clock = ~transmit_clock;
            if (transmit_clock || !tx_run) {tx_positive_rail, tx_negative_rail} = {tx_p_in, tx_n_in};
         end
         forever begin
            #62.5;
            if (rx_run || line_rx_clock) line_rx_clock = ~line_rx_clock;
            if (!line_rx_clock) {line_rx_pos, line_rx_neg} = {rx_p_in, rx_n_in};
         end
      join
   end
endmodule : tlp_far_end

// ### verification/tb_tlp_line_port.sv
`include "tlp_regs.svh"

module tb_tlp_line_port;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [1:0] OK = `TLP_RESP_OKAY;
   localparam logic [1:0] ERR = `TLP_RESP_SLVERR;
   logic        aclk, aresetn, tck, mck, txp, txn, lck, lpp, lnn, ler, vio, los, flt;
   logic        ltp, ltn, rxp, rxn, rxv, rck, oe, irq, tx_run, rx_run, tpi, tni, rpi, rni;
   logic [2:0]  seen;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int          fails, cmp_count;

   tlp_far_end i_tlp_far_end (.tx_run, .rx_run, .tx_p_in(tpi), .tx_n_in(tni), .rx_p_in(rpi), .rx_n_in(rni),
      .transmit_clock(tck), .master_clock(mck), .tx_positive_rail(txp), .tx_negative_rail(txn),
      .line_rx_clock(lck), .line_rx_pos(lpp), .line_rx_neg(lnn));

   tlp_line_port #(.TXCLK_LOSS_CYC(20)) i_tlp_line_port (.aclk, .aresetn, .transmit_clock(tck),
      .master_clock(mck), .tx_positive_rail(txp), .tx_negative_rail(txn), .insert_logic_error_in(ler),
      .insert_violation_in(vio), .line_rx_clock(lck), .line_rx_pos(lpp), .line_rx_neg(lnn),
      .loss_of_signal(los), .address_latch_strobe_float(flt), .line_tx_pos(ltp), .line_tx_neg(ltn),
      .rx_positive_rail(rxp), .rx_negative_rail(rxn), .rx_violation_flag(rxv), .recovered_clock(rck),
      .pins_oe(oe), .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   always @(posedge aclk) seen <= seen | {rxv, rck, ltn};

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask : chk_bit

   task automatic wait_clk(input int n);
      repeat (n) @(posedge aclk);
   endtask : wait_clk

   task automatic clr_seen;
      #1 seen = 3'h0;
      @(posedge aclk);
   endtask : clr_seen

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      chk_word({30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input logic [1:0] er);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      chk_word(s_axi_rdata & m, exp);
      chk_word({30'h0, s_axi_rresp}, {30'h0, er});
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd

   task automatic t_regs;
      rd(`TLP_CTRL_OFS, 32'hffffffff, 32'h0, OK);
      rd(`TLP_STATUS_OFS, 32'h3, 32'h0, OK);
      wr(`TLP_INT_MASK_OFS, 32'hffffffff, OK);
      rd(`TLP_INT_MASK_OFS, 32'hffffffff, 32'h1f, OK);
      s_axi_wstrb <= 4'he;
      wr(`TLP_CTRL_OFS, 32'h1, OK);
      s_axi_wstrb <= 4'hf;
      rd(`TLP_CTRL_OFS, 32'hffffffff, 32'h0, OK);
      wr(8'h10, 32'h1, ERR);
      rd(8'h10, 32'h0, 32'h0, ERR);
      chk_bit(oe, 1'b1);
   endtask : t_regs

   task automatic t_tx;
      {tx_run, tpi, tni} <= 3'h6;
      wait_clk(60);
      rd(`TLP_STATUS_OFS, 32'h1, 32'h1, OK);
      chk_word({ltp, ltn}, 2'h2);
      {tpi, tni} <= 2'h1;
      wait_clk(60);
      chk_word({ltp, ltn}, 2'h1);
      tx_run <= 1'b0;
      wait_clk(100);
      rd(`TLP_STATUS_OFS, 32'h1, 32'h0, OK);
      tni <= 1'b0;
      wait_clk(150);
      chk_bit(ltn, 1'b0);
   endtask : t_tx

   task automatic t_uni;
      wr(`TLP_CTRL_OFS, 32'h1, OK);
      wr(`TLP_INT_MASK_OFS, 32'h2, OK);
      {tx_run, tpi} <= 2'h3;
      wait_clk(60);
      rd(`TLP_INT_STATUS_OFS, 32'h0, 32'h0, OK);
      clr_seen;
      vio <= 1'b1;
      wait_clk(40);
      chk_bit(seen[0], 1'b1);
      chk_bit(irq, 1'b1);
      rd(`TLP_INT_STATUS_OFS, 32'h2, 32'h2, OK);
      wait_clk(2);
      chk_bit(irq, 1'b0);
      wait_clk(40);
      rd(`TLP_INT_STATUS_OFS, 32'h2, 32'h0, OK);
      vio <= 1'b0;
      wait_clk(40);
   endtask : t_uni

   task automatic t_test;
      wr(`TLP_CTRL_OFS, 32'h2, OK);
      wr(`TLP_INT_MASK_OFS, 32'h0, OK);
      rd(`TLP_INT_STATUS_OFS, 32'h0, 32'h0, OK);
      {ler, vio} <= 2'h3;
      wait_clk(40);
      chk_bit(irq, 1'b0);
      rd(`TLP_INT_STATUS_OFS, 32'h3, 32'h3, OK);
      {ler, vio} <= 2'h0;
      wait_clk(40);
      ler <= 1'b1;
      wait_clk(40);
      rd(`TLP_INT_STATUS_OFS, 32'h3, 32'h1, OK);
      ler <= 1'b0;
   endtask : t_test

   task automatic t_rx;
      wr(`TLP_CTRL_OFS, 32'h8, OK);
      wait_clk(150);
      chk_word({rxp, rxn}, 2'h2);
      wr(`TLP_CTRL_OFS, 32'h0, OK);
      {rx_run, rpi, rni} <= 3'h6;
      wait_clk(60);
      chk_word({rxp, rxn}, 2'h2);
      wr(`TLP_CTRL_OFS, 32'h4, OK);
      {rpi, rni} <= 2'h1;
      wait_clk(60);
      chk_word({rxp, rxn}, 2'h1);
      wr(`TLP_CTRL_OFS, 32'h1, OK);
      {rpi, rni} <= 2'h2;
      clr_seen;
      wait_clk(60);
      chk_word({rxp, rxn}, 2'h2);
      chk_word({30'h0, seen[2:1]}, 32'h3);
   endtask : t_rx

   task automatic t_los;
      {rx_run, los} <= 2'h1;
      wait_clk(40);
      clr_seen;
      wait_clk(200);
      rd(`TLP_STATUS_OFS, 32'h6, 32'h6, OK);
      chk_bit(seen[1], 1'b1);
      los <= 1'b0;
   endtask : t_los

   task automatic t_float;
      flt <= 1'b1;
      wait_clk(8);
      chk_bit(oe, 1'b0);
      flt <= 1'b0;
      wait_clk(8);
      chk_bit(oe, 1'b1);
   endtask : t_float

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   initial begin
      {aresetn, tx_run, rx_run, tpi, tni, rpi, rni, ler, vio, los, flt, seen} = 14'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      fails = 0;
      cmp_count = 0;
      wait_clk(20);
      aresetn <= 1'b1;
      wait_clk(4);
      t_regs;
      t_tx;
      t_uni;
      t_test;
      t_rx;
      t_los;
      t_float;
      wrap_up;
   end

   initial begin
      wait_clk(20000);
      fails++;
      wrap_up;
   end
endmodule : tb_tlp_line_port
